// [dv/bht_master_model.sv]
// Backplane master model that issues the command cycles being traced
`timescale 1ns/1ps
module bht_master_model (
    input wire logic aclk,
    output bht_pkg::bht_bus_t bus_out
);
    import bht_pkg::*;

    initial begin
        bus_out = '{cmd_n: 4'hF, default: '0};
    end

    // Strobe held len clocks; a clock after release addr, data and bm show the inverse, intr is left as it was
    task automatic cycle(input logic [1:0] kind, input logic [23:0] a, input logic [15:0] d,
                         input logic [3:0] bm, input logic [3:0] ir, input int len);
        bus_out <= '{cmd_n: ~(4'h8 >> kind), addr: a, data: d, bm: bm, intr: ir};
        repeat (len) @(posedge aclk);
        bus_out.cmd_n <= 4'hF;
        @(posedge aclk);
        bus_out.addr <= ~a;
        bus_out.data <= ~d;
        bus_out.bm <= ~bm;
    endtask
endmodule

// [dv/bht_monitor_test.sv]
// Self-checking bench for the bus history trace monitor
`timescale 1ns/1ps
`include "bht_defines.svh"
module bht_monitor_test;
    import bht_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, init_out, init_oe, fault_lamp, pass_lamp;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] int_out, int_oe;
    bht_bus_t bus;
    bht_pins_t pins;
    bht_strap_t strap = '{pf_low: 1'b0, tmo_rst: 1'b0, pf_lvl: 3'h2, buf_lvl: 3'h5, sw: 8'hEE};
    logic pf = 1'b0, mon_n = 1'b1, moff_n = 1'b1;
    int fails = 0, check_count = 0;
    logic [49:0] rq[$];
    logic [1:0] bq[$];
    logic [11:0] eptr;

    always #4 aclk = ~aclk;
    // Bus INIT is open drain with a pull-up
    assign pins = '{pf_in: pf, mrst_on_n: mon_n, mrst_off_n: moff_n,
                    init_n: init_oe ? init_out : 1'b1};

    bht_monitor #(.ENTRY_AW(10), .TIMEOUT_CYCLES(4000), .INIT_CYCLES(16)) dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .bus_in(bus), .pins_in(pins), .strap_in(strap), .init_out(init_out),
        .init_oe(init_oe), .int_out(int_out), .int_oe(int_oe),
        .fault_lamp(fault_lamp), .pass_lamp(pass_lamp)
    );
    bht_master_model bus_u (.aclk(aclk), .bus_out(bus));

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 6000) begin
            fails++;
            $display("Error wait expected event seen timeout");
            conclude();
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        logic aw_on, w_on;
        n = 0;
        aw_on = 1'b1;
        w_on = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bq.push_back(e);
        // Each channel is released at its own handshake
        do begin
            tick(n);
            if (aw_on && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_on = 1'b0;
            end
            if (w_on && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_on = 1'b0;
            end
        end while (aw_on || w_on);
        do tick(n); while (bvalid !== 1'b1);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rq.push_back({a, r, e});
        do tick(n); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do tick(n); while (rvalid !== 1'b1);
    endtask

    // Responses are taken in order, oldest note first
    always @(posedge aclk) begin
        logic [49:0] x;
        if (rvalid === 1'b1 && rq.size() > 0) begin
            x = rq.pop_front();
            chk($sformatf("read response %h", x[49:34]), {30'h0, x[33:32]}, {30'h0, rresp});
            chk($sformatf("read data %h", x[49:34]), x[31:0], rdata);
        end
        if (bvalid === 1'b1 && bq.size() > 0) begin
            chk("write response", {30'h0, bq.pop_front()}, {30'h0, bresp});
        end
    end

    task automatic trace(input logic [1:0] k, input logic [7:0] hi, input logic rec);
        logic [15:0] lo, d, ea;
        logic [3:0] bm, ir;
        lo = 16'($urandom);
        d = 16'($urandom);
        bm = 4'($urandom);
        ir = 4'($urandom);
        // Strobe length varies so both brief and long cycles are seen
        bus_u.cycle(k, {hi, lo}, d, bm, ir, 2 + int'(k));
        repeat (6) @(posedge aclk);
        eptr = eptr + 12'(rec);
        rd(`BHT_OFF_PTR, {20'h0, eptr}, `BHT_RESP_OKAY);
        if (rec) begin
            ea = {3'h0, eptr[9:0] - 10'h1, 3'h0};
            rd(ea, {lo, d}, `BHT_RESP_OKAY);
            rd(ea + 16'h4, {4'h0, ir, 4'h0, 4'h8 >> k, 4'h0, bm, hi}, `BHT_RESP_OKAY);
        end
    endtask

    initial begin
        int n;
        void'($urandom(32'heb40));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`BHT_OFF_CTRL, 32'h0, `BHT_RESP_OKAY);
        rd(`BHT_OFF_WIN, 32'h0, `BHT_RESP_OKAY);
        rd(`BHT_OFF_IRQ, 32'h0, `BHT_RESP_OKAY);
        rd(`BHT_OFF_PTR, 32'h0, `BHT_RESP_OKAY);
        rd(16'h2000, 32'h0, `BHT_RESP_DECERR);
        wr(16'h4000, 32'hFFFF_FFFF, `BHT_RESP_DECERR);
        wr(`BHT_OFF_PTR, 32'hFFFF_FFFF, `BHT_RESP_OKAY);
        rd(`BHT_OFF_PTR, 32'h0FFF, `BHT_RESP_OKAY);
        wr(`BHT_OFF_WIN, 32'hA5, `BHT_RESP_OKAY);
        rd(`BHT_OFF_WIN, 32'hA5, `BHT_RESP_OKAY);
        wr(16'h0010, 32'h1234_5678, `BHT_RESP_OKAY);
        wstrb <= 4'h2;
        wr(16'h0010, 32'hAABB_CCDD, `BHT_RESP_OKAY);
        wstrb <= 4'hF;
        rd(16'h0010, 32'h1234_CC78, `BHT_RESP_OKAY);
        $display("test registers done");
        strap.tmo_rst <= 1'b1;
        n = 0;
        do tick(n); while (init_oe !== 1'b1);
        chk("fault lamp", 32'h1, {31'h0, fault_lamp});
        n = 0;
        do tick(n); while (init_oe === 1'b1);
        chk("init pulse length", 32'd16, n);
        strap.tmo_rst <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(`BHT_OFF_CTRL, 32'h80, `BHT_RESP_OKAY);
        wr(`BHT_OFF_CTRL, 32'h0, `BHT_RESP_OKAY);
        $display("test timeout done");
        for (int i = 0; i < 2; i++) begin
            strap.pf_low <= i[0];
            pf <= ~i[0];
            repeat (6) @(posedge aclk);
            chk("power warning line", 32'h04, {24'h0, int_oe});
            chk("interrupt drive level", 32'h0, {24'h0, int_out});
            pf <= i[0];
            repeat (6) @(posedge aclk);
            chk("power warning line", 32'h00, {24'h0, int_oe});
        end
        rd(`BHT_OFF_IRQ, 32'h2, `BHT_RESP_OKAY);
        wr(`BHT_OFF_IRQ, 32'h0, `BHT_RESP_OKAY);
        rd(`BHT_OFF_IRQ, 32'h0, `BHT_RESP_OKAY);
        $display("test power warning done");
        eptr = 12'h7FE;
        wr(`BHT_OFF_PTR, 32'h7FE, `BHT_RESP_OKAY);
        wr(`BHT_OFF_CTRL, 32'h2F, `BHT_RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            trace(k[1:0], 8'h12, 1'b1);
        end
        chk("pointer interrupt line", 32'h20, {24'h0, int_oe});
        rd(`BHT_OFF_IRQ, 32'h1, `BHT_RESP_OKAY);
        wr(`BHT_OFF_CTRL, 32'h04, `BHT_RESP_OKAY);
        trace(2'd3, 8'h55, 1'b0);
        trace(2'd1, 8'hEE, 1'b0);
        trace(2'd1, 8'h55, 1'b1);
        wr(`BHT_OFF_WIN, 32'h34, `BHT_RESP_OKAY);
        wr(`BHT_OFF_CTRL, 32'h14, `BHT_RESP_OKAY);
        trace(2'd1, 8'h12, 1'b0);
        trace(2'd1, 8'h34, 1'b1);
        wr(`BHT_OFF_CTRL, 32'h0, `BHT_RESP_OKAY);
        $display("test trace done");
        wr(`BHT_OFF_CTRL, 32'hC0, `BHT_RESP_OKAY);
        chk("lamps", 32'h3, {30'h0, fault_lamp, pass_lamp});
        mon_n <= 1'b0;
        repeat (4) @(posedge aclk);
        mon_n <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("init drive", 32'h1, {31'h0, init_oe});
        chk("init drive level", 32'h0, {31'h0, init_out});
        moff_n <= 1'b0;
        repeat (4) @(posedge aclk);
        moff_n <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("init drive", 32'h0, {31'h0, init_oe});
        rd(`BHT_OFF_CTRL, 32'h0, `BHT_RESP_OKAY);
        chk("lamps", 32'h0, {30'h0, fault_lamp, pass_lamp});
        $display("test manual reset done");
        // Idle bus with the reset strap open: lamp only, no INIT
        n = 0;
        do tick(n); while (fault_lamp !== 1'b1);
        rd(`BHT_OFF_CTRL, 32'h80, `BHT_RESP_OKAY);
        chk("init drive", 32'h0, {31'h0, init_oe});
        $display("test idle timeout done");
        conclude();
    end
endmodule

// [logic/bht_monitor.sv]
// Bus history trace, inactivity reset and reset/power-fail forwarding
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "bht_defines.svh"

module bht_monitor #(
    parameter int unsigned ENTRY_AW = `BHT_ENTRY_AW_SMALL,
    parameter int unsigned TIMEOUT_CYCLES = `BHT_TIMEOUT_CYCLES,
    parameter int unsigned INIT_CYCLES = `BHT_INIT_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire bht_pkg::bht_bus_t bus_in,
    input wire bht_pkg::bht_pins_t pins_in,
    input wire bht_pkg::bht_strap_t strap_in,
    output logic init_out,
    output logic init_oe,
    output logic [7:0] int_out,
    output logic [7:0] int_oe,
    output logic fault_lamp,
    output logic pass_lamp
);
    import bht_pkg::*;

    localparam int unsigned DEPTH = 2 ** ENTRY_AW;
    localparam logic [31:0] TMO_LAST = 32'(TIMEOUT_CYCLES - 1);
    localparam logic [31:0] INIT_LAST = 32'(INIT_CYCLES - 1);

    bht_state_t st;
    bht_state_t next_st;

    // Dual-port history store; record port has priority over bus writes
    logic [63:0] mem [DEPTH];
    logic mem_we;
    logic [ENTRY_AW-1:0] mem_idx;
    logic [63:0] mem_wdata;
    logic [7:0] mem_be;

    logic [3:0] rel;
    logic self_hit;
    logic win_ok;
    logic rec_fire;
    logic strobe_change;
    logic tmo_hit;
    logic pf_asserted;
    logic buf_line;
    logic [15:0] wa;
    logic [15:0] ra;
    logic wa_ram;
    logic ra_ram;
    logic wr_take;
    logic rd_take;
    logic [63:0] rd_entry;

    assign wa = s_axi_awaddr;
    assign ra = s_axi_araddr;
    assign wa_ram = (wa >> (ENTRY_AW + 3)) == 16'h0000;
    assign ra_ram = (ra >> (ENTRY_AW + 3)) == 16'h0000;

    // A cycle ends when its strobe releases; capture holds the last asserted sample
    assign rel = st.cmd_prev & ~st.bus_s2.cmd;
    assign self_hit = (|rel[3:2]) && (st.cap.addr[23:16] == st.strap_s2.sw);
    assign win_ok = !st.ctrl[`BHT_CTRL_WINEN] || (st.cap.addr[23:16] == st.window);
    assign rec_fire = (|(rel & st.ctrl[3:0])) && win_ok && !self_hit;

    assign strobe_change = st.bus_s2.cmd != st.cmd_prev;
    assign tmo_hit = !st.init_act && !strobe_change && (st.tmo_cnt == TMO_LAST);
    assign pf_asserted = st.pin_s2.pf ^ st.strap_s2.pf_low;
    assign buf_line = st.ctrl[`BHT_CTRL_INTEN] && st.ptr[`BHT_PTR_W-1];

    // Stall bus writes while a record uses the store this cycle
    assign wr_take = s_axi_awvalid && s_axi_wvalid && !st.bvalid && !rec_fire;
    assign rd_take = s_axi_arvalid && !st.rvalid;
    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;

    assign rd_entry = mem[ra[ENTRY_AW+2:3]];

    // Open-collector lines: driven low while enabled
    assign init_out = 1'b0;
    assign init_oe = st.init_act || st.mrst;
    assign fault_lamp = st.ctrl[`BHT_CTRL_FAULT];
    assign pass_lamp = st.ctrl[`BHT_CTRL_PASS];

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_intline
            assign int_out[gi] = 1'b0;
            assign int_oe[gi] = (pf_asserted && st.strap_s2.pf_lvl == 3'(gi)) ||
                (buf_line && st.strap_s2.buf_lvl == 3'(gi));
        end
    endgenerate

    always_comb begin
        next_st = st;
        mem_we = 1'b0;
        mem_idx = '0;
        mem_wdata = '0;
        mem_be = 8'h00;

        // Two-stage sampling of every pin
        next_st.bus_s1 = '{cmd: ~bus_in.cmd_n, addr: bus_in.addr, data: bus_in.data,
            bm: bus_in.bm, intr: bus_in.intr};
        next_st.bus_s2 = st.bus_s1;
        next_st.pin_s1 = '{pf: pins_in.pf_in, mrst_on: !pins_in.mrst_on_n,
            mrst_off: !pins_in.mrst_off_n, init: !pins_in.init_n};
        next_st.pin_s2 = st.pin_s1;
        next_st.strap_s1 = strap_in;
        next_st.strap_s2 = st.strap_s1;
        next_st.cmd_prev = st.bus_s2.cmd;
        if (|st.bus_s2.cmd) begin
            next_st.cap = st.bus_s2;
        end

        // Record into the slot the pointer names, then step it
        if (rec_fire) begin
            mem_we = 1'b1;
            mem_idx = st.ptr[ENTRY_AW-1:0];
            // Upper word {0, intr, 0, types, 0, master id, A23..16}; unused bits store zero
            mem_wdata = {4'h0, st.cap.intr, 4'h0, rel & st.ctrl[3:0], 4'h0, st.cap.bm,
                st.cap.addr[23:16], st.cap.addr[15:0], st.cap.data};
            mem_be = 8'hFF;
            next_st.ptr = st.ptr + 12'h001;
        end

        // Bus write side
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (wr_take) begin
            next_st.bvalid = 1'b1;
            next_st.bresp = `BHT_RESP_OKAY;
            if (wa_ram) begin
                mem_we = 1'b1;
                mem_idx = wa[ENTRY_AW+2:3];
                mem_wdata = {s_axi_wdata, s_axi_wdata};
                mem_be = wa[2] ? {s_axi_wstrb, 4'h0} : {4'h0, s_axi_wstrb};
            end else if (wa == `BHT_OFF_PTR) begin
                if (s_axi_wstrb[0]) begin
                    next_st.ptr[7:0] = s_axi_wdata[7:0];
                end
                if (s_axi_wstrb[1]) begin
                    next_st.ptr[11:8] = s_axi_wdata[11:8];
                end
            end else if (wa == `BHT_OFF_WIN) begin
                if (s_axi_wstrb[0]) begin
                    next_st.window = s_axi_wdata[7:0];
                end
            end else if (wa == `BHT_OFF_CTRL) begin
                if (s_axi_wstrb[0]) begin
                    next_st.ctrl = s_axi_wdata[7:0];
                end
            end else if (wa == `BHT_OFF_IRQ) begin
                if (s_axi_wstrb[0]) begin
                    next_st.irq = s_axi_wdata[1:0];
                end
            end else begin
                next_st.bresp = `BHT_RESP_DECERR;
            end
        end

        // Bus read side
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (rd_take) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = `BHT_RESP_OKAY;
            next_st.rdata = 32'h0000_0000;
            if (ra_ram) begin
                next_st.rdata = ra[2] ? rd_entry[63:32] : rd_entry[31:0];
            end else if (ra == `BHT_OFF_PTR) begin
                next_st.rdata = {20'h00000, st.ptr};
            end else if (ra == `BHT_OFF_WIN) begin
                next_st.rdata = {24'h000000, st.window};
            end else if (ra == `BHT_OFF_CTRL) begin
                next_st.rdata = {24'h000000, st.ctrl};
            end else if (ra == `BHT_OFF_IRQ) begin
                next_st.rdata = {30'h00000000, st.irq};
            end else begin
                next_st.rresp = `BHT_RESP_DECERR;
            end
        end

        // Break-before-make switch: each contact sets or clears the latch
        if (st.pin_s2.mrst_on) begin
            next_st.mrst = 1'b1;
        end else if (st.pin_s2.mrst_off) begin
            next_st.mrst = 1'b0;
        end

        // Inactivity timer; held at zero while our own reset pulse is out
        if (st.init_act || strobe_change || tmo_hit) begin
            next_st.tmo_cnt = 32'h0000_0000;
        end else begin
            next_st.tmo_cnt = st.tmo_cnt + 32'h0000_0001;
        end
        if (st.init_act) begin
            if (st.init_cnt == INIT_LAST) begin
                next_st.init_act = 1'b0;
            end else begin
                next_st.init_cnt = st.init_cnt + 32'h0000_0001;
            end
        end

        // Bus INIT clears config; fault lamp only by a manual reset
        if (st.pin_s2.init) begin
            next_st.ctrl[6:0] = 7'h00;
            next_st.window = `BHT_WIN_RESET;
            next_st.irq = `BHT_IRQ_RESET;
            if (st.mrst) begin
                next_st.ctrl[`BHT_CTRL_FAULT] = 1'b0;
            end
        end

        // Hardware sets come last so they beat any clear
        if (tmo_hit) begin
            next_st.ctrl[`BHT_CTRL_FAULT] = 1'b1;
            if (st.strap_s2.tmo_rst) begin
                next_st.init_act = 1'b1;
                next_st.init_cnt = 32'h0000_0000;
            end
        end
        if (pf_asserted) begin
            next_st.irq[`BHT_IRQ_PF] = 1'b1;
        end
        if (!st.ptr[`BHT_PTR_W-1] && next_st.ptr[`BHT_PTR_W-1]) begin
            next_st.irq[`BHT_IRQ_BUF] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Byte-lane writes into the history store
    always_ff @(posedge aclk) begin
        if (mem_we) begin
            for (int b = 0; b < 8; b++) begin
                if (mem_be[b]) begin
                    mem[mem_idx][b*8 +: 8] <= mem_wdata[b*8 +: 8];
                end
            end
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ptr_step_a: assert property (rec_fire |=> st.ptr == $past(st.ptr) + 12'h001)
        else $error("pointer did not advance by one on record");

    type_enable_a: assert property (
        (rel & ~st.ctrl[3:0]) != 4'h0 && (rel & st.ctrl[3:0]) == 4'h0 && !wr_take
        |=> st.ptr == $past(st.ptr))
        else $error("record of a disabled cycle type");

    window_filter_a: assert property (
        (|rel) && st.ctrl[`BHT_CTRL_WINEN] && st.cap.addr[23:16] != st.window && !wr_take
        |=> st.ptr == $past(st.ptr))
        else $error("record outside the selected segment");

    self_skip_a: assert property (
        (|rel[3:2]) && st.cap.addr[23:16] == st.strap_s2.sw && !wr_take
        |=> st.ptr == $past(st.ptr))
        else $error("access to this board was recorded");

    entry_store_a: assert property (
        rec_fire && !wr_take |=> mem[$past(st.ptr[ENTRY_AW-1:0])][31:0] ==
            $past({st.cap.addr[15:0], st.cap.data}))
        else $error("entry low word not stored at pointer slot");

    tmo_lamp_a: assert property (tmo_hit |=> fault_lamp ##1 fault_lamp || st.pin_s2.init)
        else $error("timeout did not set the fault lamp");

    tmo_init_a: assert property (
        tmo_hit && st.strap_s2.tmo_rst |=> init_oe && st.init_cnt == 32'h0000_0000)
        else $error("timeout did not start the reset pulse");

    tmo_norst_a: assert property (
        tmo_hit && !st.strap_s2.tmo_rst && !st.init_act && !st.mrst |=> !init_oe)
        else $error("timeout reset despite strap");

    timer_reload_a: assert property (strobe_change |=> st.tmo_cnt == 32'h0000_0000)
        else $error("strobe edge did not reload the timer");

    mrst_init_a: assert property (st.pin_s2.mrst_on |=> init_oe)
        else $error("manual reset not driven onto INIT");

    pf_line_a: assert property (
        pf_asserted |-> int_oe[st.strap_s2.pf_lvl])
        else $error("power warning not forwarded");

    buf_irq_a: assert property (
        st.ctrl[`BHT_CTRL_INTEN] && st.ptr[11] |-> int_oe[st.strap_s2.buf_lvl])
        else $error("pointer interrupt not requested");

    ptr_read_a: assert property (
        rd_take && ra == `BHT_OFF_PTR |=> s_axi_rvalid && s_axi_rdata[31:12] == 20'h00000)
        else $error("pointer upper bits not zero");

    // Hardware sets must survive a same-cycle software clear
    pf_irq_a: assert property (pf_asserted |=> st.irq[`BHT_IRQ_PF])
        else $error("power warning not latched in interrupt register");

    buf_irq_set_a: assert property (
        rec_fire && st.ptr == 12'h7FF |=> st.irq[`BHT_IRQ_BUF])
        else $error("pointer top crossing not latched");

    ctrl_init_clear_a: assert property (
        st.pin_s2.init |=> st.ctrl[6:0] == 7'h00 && st.window == 8'h00)
        else $error("bus INIT did not clear the configuration");

    fault_keep_a: assert property (
        st.pin_s2.init && !st.mrst && fault_lamp && !wr_take |=> fault_lamp)
        else $error("fault lamp lost in an automatic reset");

    ptr_load_a: assert property (
        wr_take && wa == `BHT_OFF_PTR && s_axi_wstrb[1:0] == 2'h3
        |=> st.ptr == $past(s_axi_wdata[11:0]))
        else $error("pointer load lost");

    win_load_a: assert property (
        wr_take && wa == `BHT_OFF_WIN && s_axi_wstrb[0] && !st.pin_s2.init
        |=> st.window == $past(s_axi_wdata[7:0]))
        else $error("window register load lost");

    init_hold_a: assert property (
        st.init_act && st.init_cnt != INIT_LAST |=> init_oe)
        else $error("reset pulse ended early");

endmodule

// [shared/bht_defines.svh]
// Offsets, field positions, reset values and timing counts of the bus history trace block
`ifndef BHT_DEFINES_SVH
`define BHT_DEFINES_SVH

`define BHT_OFF_PTR 16'h8000
`define BHT_OFF_WIN 16'hA000
`define BHT_OFF_CTRL 16'hC000
`define BHT_OFF_IRQ 16'hE000

`define BHT_CTRL_FAULT 7
`define BHT_CTRL_PASS 6
`define BHT_CTRL_INTEN 5
`define BHT_CTRL_WINEN 4
`define BHT_IRQ_PF 1
`define BHT_IRQ_BUF 0

`define BHT_PTR_W 12
`define BHT_ENTRY_AW_SMALL 10
`define BHT_ENTRY_AW_LARGE 12
`define BHT_CTRL_RESET 8'h00
`define BHT_WIN_RESET 8'h00
`define BHT_IRQ_RESET 2'h0

`define BHT_RESP_OKAY 2'h0
`define BHT_RESP_DECERR 2'h3

`define BHT_CLK_KHZ 125000
`define BHT_TIMEOUT_MS 3000
`define BHT_INIT_MS 3000
`define BHT_TIMEOUT_CYCLES (`BHT_TIMEOUT_MS * `BHT_CLK_KHZ)
`define BHT_INIT_CYCLES (`BHT_INIT_MS * `BHT_CLK_KHZ)

`endif

// [shared/bht_pkg.sv]
// Types of the bus history trace block
package bht_pkg;

    // Monitored backplane signals at the pins, strobes active low
    typedef struct packed {
        logic [3:0] cmd_n;
        logic [23:0] addr;
        logic [15:0] data;
        logic [3:0] bm;
        logic [3:0] intr;
    } bht_bus_t;

    // Same signals after sampling, strobes active high
    typedef struct packed {
        logic [3:0] cmd;
        logic [23:0] addr;
        logic [15:0] data;
        logic [3:0] bm;
        logic [3:0] intr;
    } bht_smp_t;

    typedef struct packed {
        logic pf_in;
        logic mrst_on_n;
        logic mrst_off_n;
        logic init_n;
    } bht_pins_t;

    typedef struct packed {
        logic pf;
        logic mrst_on;
        logic mrst_off;
        logic init;
    } bht_pinsmp_t;

    typedef struct packed {
        logic pf_low;
        logic tmo_rst;
        logic [2:0] pf_lvl;
        logic [2:0] buf_lvl;
        logic [7:0] sw;
    } bht_strap_t;

    typedef struct packed {
        bht_smp_t bus_s1;
        bht_smp_t bus_s2;
        bht_pinsmp_t pin_s1;
        bht_pinsmp_t pin_s2;
        bht_strap_t strap_s1;
        bht_strap_t strap_s2;
        logic [3:0] cmd_prev;
        bht_smp_t cap;
        logic [11:0] ptr;
        logic [7:0] ctrl;
        logic [7:0] window;
        logic [1:0] irq;
        logic [31:0] tmo_cnt;
        logic [31:0] init_cnt;
        logic init_act;
        logic mrst;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } bht_state_t;

endpackage
